/* File: ttc_pkg.sv */
// Constants and types shared by the timer unit
`default_nettype none
package ttc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_AB_CTRL = 8'h88;
  localparam logic [7:0] IDX_AB_MODE = 8'h89;
  localparam logic [7:0] IDX_A_LOW   = 8'h8A;
  localparam logic [7:0] IDX_B_LOW   = 8'h8B;
  localparam logic [7:0] IDX_A_HIGH  = 8'h8C;
  localparam logic [7:0] IDX_B_HIGH  = 8'h8D;
  localparam logic [7:0] IDX_C_CTRL  = 8'hC8;
  localparam logic [7:0] IDX_C_RL_LO = 8'hCA;
  localparam logic [7:0] IDX_C_RL_HI = 8'hCB;
  localparam logic [7:0] IDX_C_CNT_LO = 8'hCC;
  localparam logic [7:0] IDX_C_CNT_HI = 8'hCD;
  // Control register bits of timers A and B
  localparam int AB_B_OVF = 7;
  localparam int AB_B_RUN = 6;
  localparam int AB_A_OVF = 5;
  localparam int AB_A_RUN = 4;
  // Mode register fields
  localparam int MD_B_GATE = 7;
  localparam int MD_B_CT   = 6;
  localparam int MD_B_MODE = 4;
  localparam int MD_A_GATE = 3;
  localparam int MD_A_CT   = 2;
  localparam int MD_A_MODE = 0;
  // Timer C control bits
  localparam int C_OVF  = 7;
  localparam int C_EXT  = 6;
  localparam int C_RXS  = 5;
  localparam int C_TXS  = 4;
  localparam int C_TEN  = 3;
  localparam int C_RUN  = 2;
  localparam int C_FUNC = 1;
  localparam int C_CAP  = 0;
  // Pin vector positions
  localparam int PIN_IRQ_A = 0;
  localparam int PIN_IRQ_B = 1;
  localparam int PIN_CNT_A = 2;
  localparam int PIN_CNT_B = 3;
  localparam int PIN_CNT_C = 4;
  localparam int PIN_TRIG  = 5;
  localparam int NUM_PINS  = 6;
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef enum logic [1:0] {MODE_13, MODE_16, MODE_8_RELOAD, MODE_SPLIT} ttc_mode_t;
endpackage : ttc_pkg
`default_nettype wire

/* File: ttc_tmr_if.sv */
// Bundle between the top and one timer A/B next-count unit
`default_nettype none
interface ttc_tmr_if;
  import ttc_pkg::*;
  ttc_mode_t  mode;
  logic       gate;
  logic       ct;
  logic       run;
  logic       gate_pin;
  logic       cnt_fall;
  logic [7:0] low;
  logic [7:0] high;
  logic [7:0] nxt_low;
  logic [7:0] nxt_high;
  logic       ovf;
  logic       ovf_high;
  modport ctl (output mode, gate, ct, run, gate_pin, cnt_fall, low, high,
               input nxt_low, nxt_high, ovf, ovf_high);
  modport tmr (input mode, gate, ct, run, gate_pin, cnt_fall, low, high,
               output nxt_low, nxt_high, ovf, ovf_high);
endinterface : ttc_tmr_if
`default_nettype wire

/* File: ttc_sync_edge.sv */
// Two-stage pin synchroniser with falling-edge detect
`default_nettype none
module ttc_sync_edge #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } ttc_sync_t;
  ttc_sync_t s_r;
  ttc_sync_t s_nxt;
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = pin_in;
    s_nxt.sync = s_r.meta;
    s_nxt.prev = s_r.sync;
  end
  // Pins idle high, so reset to ones avoids a false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign level = s_r.sync;
  assign fall  = s_r.prev & ~s_r.sync; // RULE22
endmodule : ttc_sync_edge
`default_nettype wire

/* File: ttc_timer_ab.sv */
// Next count and overflow of one timer A/B
`default_nettype none
module ttc_timer_ab
  import ttc_pkg::*;
#(
  parameter bit IS_A = 1'b1
) (
  ttc_tmr_if.tmr      t,
  input  wire logic   b_run
);
  always_comb begin
    logic       en;
    logic [13:0] s13;
    logic [8:0]  s8;
    logic [8:0]  h8;
    en  = t.run && (!t.gate || t.gate_pin) && (!t.ct || t.cnt_fall); // RULE3 RULE5 RULE21
    s13 = {1'b0, t.high, t.low[4:0]} + 14'h0001;
    s8  = {1'b0, t.low} + 9'h001;
    h8  = {1'b0, t.high} + 9'h001;
    t.nxt_low  = t.low;
    t.nxt_high = t.high;
    t.ovf      = 1'b0;
    t.ovf_high = 1'b0;
    case (t.mode)
      MODE_13: begin
        if (en) begin
          // Top three low bits are left as they are
          {t.ovf, t.nxt_high, t.nxt_low[4:0]} = s13; // RULE1
        end
      end
      MODE_16: begin
        if (en) begin
          {t.ovf, t.nxt_high, t.nxt_low} = {1'b0, t.high, t.low} + 17'h00001; // RULE6
        end
      end
      MODE_8_RELOAD: begin
        if (en) begin
          t.ovf     = s8[8];
          t.nxt_low = s8[8] ? t.high : s8[7:0]; // RULE7
        end
      end
      MODE_SPLIT: begin
        // Timer B holds its count here
        if (IS_A) begin // RULE8
          if (en) begin
            {t.ovf, t.nxt_low} = s8;
          end
          if (b_run) begin
            {t.ovf_high, t.nxt_high} = h8; // RULE9
          end
        end
      end
      default: begin
        t.ovf = 1'b0;
      end
    endcase
  end
endmodule : ttc_timer_ab
`default_nettype wire

/* File: ttc_timer_unit.sv */
// Three-timer unit with Avalon-MM register slave
`default_nettype none
// Function
// RULE1 - Mode 0 counts thirteen bits
// RULE2 - Wrap to zero sets overflow flag
// RULE3 - Count only when run and gate allow
// RULE4 - Run bit does not touch counts
// RULE5 - No divide-by-twelve prescaler
// RULE6 - Mode 1 counts full sixteen bits
// RULE7 - Mode 2 low byte reloads from high
// RULE8 - Timer B mode 3 freezes count
// RULE9 - Timer A mode 3 splits in two
// RULE10 - Timer B mode switch starts, stops it
// RULE11 - Timer C flag blocked in baud mode
// RULE12 - Trigger edge sets external flag
// RULE13 - Receive baud source select
// RULE14 - Transmit baud source select
// RULE15 - Trigger edge acts only when enabled
// RULE16 - Timer C run bit gates counting
// RULE17 - Function bit picks pin or clock
// RULE18 - Capture select, forced reload in baud
// RULE19 - Capture copies count to reload pair
// RULE20 - Reload loads count from pair
// RULE21 - Mode field and counter select bits
// RULE22 - Pins synchronised, falling edges detected
module ttc_timer_unit
  import ttc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  input  wire logic        timer_a_count_pin,
  input  wire logic        timer_b_count_pin,
  input  wire logic        timer_c_count_pin,
  input  wire logic        timer_c_trigger_pin,
  output logic             serial_rx_baud_tick,
  output logic             serial_tx_baud_tick,
  output logic             timer_a_overflow_flag,
  output logic             timer_b_overflow_flag,
  output logic             timer_c_overflow_flag,
  output logic             timer_c_external_flag
);

  typedef struct packed {
    logic [7:0]  ab_ctrl;
    logic [7:0]  ab_mode;
    logic [7:0]  a_low;
    logic [7:0]  a_high;
    logic [7:0]  b_low;
    logic [7:0]  b_high;
    logic [7:0]  c_ctrl;
    logic [7:0]  c_rl_lo;
    logic [7:0]  c_rl_hi;
    logic [7:0]  c_cnt_lo;
    logic [7:0]  c_cnt_hi;
    logic        wait_req;
    logic [31:0] rdata;
    logic        rx_tick;
    logic        tx_tick;
  } ttc_state_t;

  ttc_state_t s_r;
  ttc_state_t s_nxt;

  logic [NUM_PINS-1:0] pin_lvl;
  logic [NUM_PINS-1:0] pin_fall;
  logic [7:0]          idx;
  logic                req;
  logic                wr_acc;
  logic                a_split;
  logic                baud;
  logic [15:0]         c_cnt;
  logic [15:0]         c_rl;
  logic                c_en;
  logic                c_ovf;
  logic                c_trig;
  logic                b_ovf;

  ttc_tmr_if tif_a ();
  ttc_tmr_if tif_b ();

  ttc_sync_edge #(
    .W (NUM_PINS)
  ) u_sync (
    .clk    (ref_clk),
    .rst    (rst),
    .pin_in ({timer_c_trigger_pin, timer_c_count_pin, timer_b_count_pin,
              timer_a_count_pin, ext_irq_b_pin, ext_irq_a_pin}),
    .level  (pin_lvl),
    .fall   (pin_fall)
  );

  ttc_timer_ab #(
    .IS_A (1'b1)
  ) u_tmr_a (
    .t     (tif_a.tmr),
    .b_run (s_r.ab_ctrl[AB_B_RUN])
  );

  ttc_timer_ab #(
    .IS_A (1'b0)
  ) u_tmr_b (
    .t     (tif_b.tmr),
    .b_run (1'b0)
  );

  assign idx     = avs_address[9:2];
  assign req     = avs_read || avs_write;
  assign wr_acc  = avs_write && !s_r.wait_req && avs_byteenable[0];
  assign a_split = ttc_mode_t'(s_r.ab_mode[MD_A_MODE +: 2]) == MODE_SPLIT;

  // Timer A inputs
  assign tif_a.mode     = ttc_mode_t'(s_r.ab_mode[MD_A_MODE +: 2]);
  assign tif_a.gate     = s_r.ab_mode[MD_A_GATE];
  assign tif_a.ct       = s_r.ab_mode[MD_A_CT];
  assign tif_a.run      = s_r.ab_ctrl[AB_A_RUN];
  assign tif_a.gate_pin = pin_lvl[PIN_IRQ_A];
  assign tif_a.cnt_fall = pin_fall[PIN_CNT_A];
  assign tif_a.low      = s_r.a_low;
  assign tif_a.high     = s_r.a_high;

  // Timer B loses its run bit to timer A's high byte in split mode
  assign tif_b.mode     = ttc_mode_t'(s_r.ab_mode[MD_B_MODE +: 2]);
  assign tif_b.gate     = s_r.ab_mode[MD_B_GATE];
  assign tif_b.ct       = s_r.ab_mode[MD_B_CT];
  assign tif_b.run      = a_split ? 1'b1 : s_r.ab_ctrl[AB_B_RUN]; // RULE10
  assign tif_b.gate_pin = pin_lvl[PIN_IRQ_B];
  assign tif_b.cnt_fall = pin_fall[PIN_CNT_B];
  assign tif_b.low      = s_r.b_low;
  assign tif_b.high     = s_r.b_high;
  assign b_ovf          = tif_b.ovf;

  // Timer C
  assign baud   = s_r.c_ctrl[C_RXS] || s_r.c_ctrl[C_TXS];
  assign c_cnt  = {s_r.c_cnt_hi, s_r.c_cnt_lo};
  assign c_rl   = {s_r.c_rl_hi, s_r.c_rl_lo};
  assign c_en   = s_r.c_ctrl[C_RUN] && (!s_r.c_ctrl[C_FUNC] || pin_fall[PIN_CNT_C]); // RULE16 RULE17
  assign c_ovf  = c_en && (c_cnt == 16'hFFFF);
  assign c_trig = s_r.c_ctrl[C_TEN] && pin_fall[PIN_TRIG]; // RULE15

  always_comb begin
    logic [15:0] c_next;
    c_next = c_cnt;
    s_nxt  = s_r;

    // Timer A and B counts
    s_nxt.a_low  = tif_a.nxt_low;
    s_nxt.a_high = tif_a.nxt_high;
    s_nxt.b_low  = tif_b.nxt_low;
    s_nxt.b_high = tif_b.nxt_high;

    // Timer C count, reload and capture
    if (c_en) begin
      if (c_ovf && (baud || !s_r.c_ctrl[C_CAP])) begin
        c_next = c_rl; // RULE18 RULE20
      end else begin
        c_next = c_cnt + 16'h0001;
      end
    end
    if (c_trig && !baud) begin
      if (s_r.c_ctrl[C_CAP]) begin
        s_nxt.c_rl_lo = s_r.c_cnt_lo; // RULE19
        s_nxt.c_rl_hi = s_r.c_cnt_hi; // RULE19
      end else begin
        c_next = c_rl; // RULE20
      end
    end
    s_nxt.c_cnt_lo = c_next[7:0];
    s_nxt.c_cnt_hi = c_next[15:8];

    // Baud ticks for the serial port
    s_nxt.rx_tick = s_r.c_ctrl[C_RXS] ? c_ovf : b_ovf; // RULE13 RULE10
    s_nxt.tx_tick = s_r.c_ctrl[C_TXS] ? c_ovf : b_ovf; // RULE14 RULE10

    // Bus handshake: one wait cycle, then accept
    if (req && s_r.wait_req) begin
      s_nxt.wait_req = 1'b0;
      s_nxt.rdata    = 32'h00000000;
      if (avs_read) begin
        case (idx)
          IDX_AB_CTRL:  s_nxt.rdata[7:0] = s_r.ab_ctrl;
          IDX_AB_MODE:  s_nxt.rdata[7:0] = s_r.ab_mode;
          IDX_A_LOW:    s_nxt.rdata[7:0] = s_r.a_low;
          IDX_B_LOW:    s_nxt.rdata[7:0] = s_r.b_low;
          IDX_A_HIGH:   s_nxt.rdata[7:0] = s_r.a_high;
          IDX_B_HIGH:   s_nxt.rdata[7:0] = s_r.b_high;
          IDX_C_CTRL:   s_nxt.rdata[7:0] = s_r.c_ctrl;
          IDX_C_RL_LO:  s_nxt.rdata[7:0] = s_r.c_rl_lo;
          IDX_C_RL_HI:  s_nxt.rdata[7:0] = s_r.c_rl_hi;
          IDX_C_CNT_LO: s_nxt.rdata[7:0] = s_r.c_cnt_lo;
          IDX_C_CNT_HI: s_nxt.rdata[7:0] = s_r.c_cnt_hi;
          default:      s_nxt.rdata[7:0] = 8'h00;
        endcase
      end
    end else begin
      s_nxt.wait_req = 1'b1;
    end

    // Software writes override hardware counting
    if (wr_acc) begin
      case (idx)
        IDX_AB_CTRL:  s_nxt.ab_ctrl  = avs_writedata[7:0]; // RULE4
        IDX_AB_MODE:  s_nxt.ab_mode  = avs_writedata[7:0]; // RULE21
        IDX_A_LOW:    s_nxt.a_low    = avs_writedata[7:0];
        IDX_B_LOW:    s_nxt.b_low    = avs_writedata[7:0];
        IDX_A_HIGH:   s_nxt.a_high   = avs_writedata[7:0];
        IDX_B_HIGH:   s_nxt.b_high   = avs_writedata[7:0];
        IDX_C_CTRL:   s_nxt.c_ctrl   = avs_writedata[7:0];
        IDX_C_RL_LO:  s_nxt.c_rl_lo  = avs_writedata[7:0];
        IDX_C_RL_HI:  s_nxt.c_rl_hi  = avs_writedata[7:0];
        IDX_C_CNT_LO: s_nxt.c_cnt_lo = avs_writedata[7:0];
        IDX_C_CNT_HI: s_nxt.c_cnt_hi = avs_writedata[7:0];
        default:      s_nxt.rdata    = s_nxt.rdata;
      endcase
    end

    // Hardware sets win over software clears
    if (tif_a.ovf) begin
      s_nxt.ab_ctrl[AB_A_OVF] = 1'b1; // RULE2
    end
    if (a_split ? tif_a.ovf_high : b_ovf) begin
      s_nxt.ab_ctrl[AB_B_OVF] = 1'b1; // RULE2 RULE9
    end
    if (c_ovf && !baud) begin
      s_nxt.c_ctrl[C_OVF] = 1'b1; // RULE11
    end
    if (c_trig) begin
      s_nxt.c_ctrl[C_EXT] = 1'b1; // RULE12
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r          <= '0;
      s_r.ab_ctrl  <= REG_RESET;
      s_r.ab_mode  <= REG_RESET;
      s_r.c_ctrl   <= REG_RESET;
      s_r.wait_req <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata          = s_r.rdata;
  assign avs_waitrequest       = s_r.wait_req;
  assign serial_rx_baud_tick   = s_r.rx_tick;
  assign serial_tx_baud_tick   = s_r.tx_tick;
  assign timer_a_overflow_flag = s_r.ab_ctrl[AB_A_OVF];
  assign timer_b_overflow_flag = s_r.ab_ctrl[AB_B_OVF];
  assign timer_c_overflow_flag = s_r.c_ctrl[C_OVF];
  assign timer_c_external_flag = s_r.c_ctrl[C_EXT];

  a_a_stop_hold: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    (!a_split && !s_r.ab_ctrl[AB_A_RUN] && !wr_acc)
    |=> ({s_r.a_high, s_r.a_low} == $past({s_r.a_high, s_r.a_low})))
    else $error("timer A counted while stopped");

  a_a_gate_hold: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    (!a_split && s_r.ab_mode[MD_A_GATE] && !pin_lvl[PIN_IRQ_A] && !wr_acc)
    |=> $stable(s_r.a_low))
    else $error("timer A counted with gate pin low");

  a_a_mode1_step: assert property (@(posedge ref_clk) disable iff (rst) // RULE6 RULE5
    (s_r.ab_mode[MD_A_MODE +: 2] == 2'h1 && s_r.ab_ctrl[AB_A_RUN]
     && !s_r.ab_mode[MD_A_GATE] && !s_r.ab_mode[MD_A_CT] && !wr_acc)
    |=> ({s_r.a_high, s_r.a_low} == $past({s_r.a_high, s_r.a_low}) + 16'h0001))
    else $error("timer A mode 1 did not step by one");

  a_a_reload: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    (s_r.ab_mode[MD_A_MODE +: 2] == 2'h2 && tif_a.ovf && !wr_acc)
    |=> (s_r.a_low == $past(s_r.a_high)) && $stable(s_r.a_high)
        && s_r.ab_ctrl[AB_A_OVF])
    else $error("timer A mode 2 reload wrong");

  a_b_freeze: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
    (s_r.ab_mode[MD_B_MODE +: 2] == 2'h3 && !wr_acc)
    |=> ({s_r.b_high, s_r.b_low} == $past({s_r.b_high, s_r.b_low})))
    else $error("timer B moved in mode 3");

  a_c_stop_hold: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
    (!s_r.c_ctrl[C_RUN] && !c_trig && !wr_acc) |=> $stable(c_cnt))
    else $error("timer C counted while stopped");

  a_c_baud_flag: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
    (baud && !s_r.c_ctrl[C_OVF] && !wr_acc) |=> !s_r.c_ctrl[C_OVF])
    else $error("timer C flag set in baud mode");

  a_c_capture: assert property (@(posedge ref_clk) disable iff (rst) // RULE19 RULE12
    (c_trig && !baud && s_r.c_ctrl[C_CAP] && !wr_acc)
    |=> (c_rl == $past(c_cnt)) && s_r.c_ctrl[C_EXT])
    else $error("timer C capture wrong");

  a_c_ovf_reload: assert property (@(posedge ref_clk) disable iff (rst) // RULE20 RULE18
    (c_ovf && !c_trig && (baud || !s_r.c_ctrl[C_CAP]) && !wr_acc)
    |=> (c_cnt == $past(c_rl)))
    else $error("timer C overflow reload wrong");

  a_tx_source: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    (!s_r.c_ctrl[C_TXS] && b_ovf) |=> serial_tx_baud_tick)
    else $error("transmit tick not from timer B");

  a_bus_wait: assert property (@(posedge ref_clk) disable iff (rst)
    (req && s_r.wait_req) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  a_rx_source: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    (!s_r.c_ctrl[C_RXS] && b_ovf) |=> serial_rx_baud_tick)
    else $error("receive tick not from timer B");

  a_c_rx_tick: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    (s_r.c_ctrl[C_RXS] && c_ovf) |=> serial_rx_baud_tick)
    else $error("receive tick not from timer C");

  a_c_tx_tick: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    (s_r.c_ctrl[C_TXS] && c_ovf) |=> serial_tx_baud_tick)
    else $error("transmit tick not from timer C");

  a_c_ovf_flag: assert property (@(posedge ref_clk) disable iff (rst) // RULE11 RULE2
    (c_ovf && !baud) |=> s_r.c_ctrl[C_OVF])
    else $error("timer C overflow flag not set");

  a_a_split_high: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
    (a_split && s_r.ab_ctrl[AB_B_RUN] && !wr_acc)
    |=> (s_r.a_high == $past(s_r.a_high) + 8'h01))
    else $error("split high byte did not step");

  a_c_trig_reload: assert property (@(posedge ref_clk) disable iff (rst) // RULE20 RULE12
    (c_trig && !baud && !s_r.c_ctrl[C_CAP] && !wr_acc)
    |=> (c_cnt == $past(c_rl)) && s_r.c_ctrl[C_EXT])
    else $error("timer C trigger reload wrong");

  a_c_trig_off: assert property (@(posedge ref_clk) disable iff (rst) // RULE15
    (!s_r.c_ctrl[C_TEN] && !s_r.c_ctrl[C_EXT] && !wr_acc)
    |=> !s_r.c_ctrl[C_EXT] && $stable(c_rl))
    else $error("timer C trigger acted while disabled");

  a_a_mode0_top: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    (s_r.ab_mode[MD_A_MODE +: 2] == 2'h0 && !wr_acc) |=> $stable(s_r.a_low[7:5]))
    else $error("timer A mode 0 changed top low bits");

endmodule : ttc_timer_unit
`default_nettype wire

/* File: ttc_end.sv */
// Unused
`default_nettype none
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the three-timer unit
`default_nettype none
module tb_top
  import ttc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk             = 1'b0;
  logic        rst                 = 1'b1;
  logic [9:0]  avs_address         = 10'h000;
  logic        avs_read            = 1'b0;
  logic        avs_write           = 1'b0;
  logic [31:0] avs_writedata       = 32'h00000000;
  logic [3:0]  avs_byteenable      = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_irq_a_pin       = 1'b1;
  logic        ext_irq_b_pin       = 1'b1;
  logic        timer_a_count_pin   = 1'b1;
  logic        timer_b_count_pin   = 1'b1;
  logic        timer_c_count_pin   = 1'b1;
  logic        timer_c_trigger_pin = 1'b1;
  logic        serial_rx_baud_tick;
  logic        serial_tx_baud_tick;
  logic        timer_a_overflow_flag;
  logic        timer_b_overflow_flag;
  logic        timer_c_overflow_flag;
  logic        timer_c_external_flag;
  logic [7:0]  rd;
  int          mismatches          = 0;
  int          total_checks        = 0;
  int          rx_ticks            = 0;
  int          tx_ticks            = 0;
  int          rx0;
  int          tx0;
  logic [7:0]  regs [11] = '{IDX_AB_CTRL, IDX_AB_MODE, IDX_A_LOW, IDX_B_LOW, IDX_A_HIGH,
                             IDX_B_HIGH, IDX_C_CTRL, IDX_C_RL_LO, IDX_C_RL_HI,
                             IDX_C_CNT_LO, IDX_C_CNT_HI};
  logic [7:0]  hw   [3]  = '{8'hFF, 8'hFF, 8'hC0};
  logic [7:0]  he   [3]  = '{8'h00, 8'h00, 8'hC0};
  logic [7:0]  msk  [3]  = '{8'hE0, 8'hE0, 8'hC0};
  logic [7:0]  top  [3]  = '{8'hE0, 8'h00, 8'hC0};

  ttc_timer_unit ttc_timer_unit_i (
    .ref_clk               (ref_clk),
    .rst                   (rst),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_byteenable        (avs_byteenable),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .ext_irq_a_pin         (ext_irq_a_pin),
    .ext_irq_b_pin         (ext_irq_b_pin),
    .timer_a_count_pin     (timer_a_count_pin),
    .timer_b_count_pin     (timer_b_count_pin),
    .timer_c_count_pin     (timer_c_count_pin),
    .timer_c_trigger_pin   (timer_c_trigger_pin),
    .serial_rx_baud_tick   (serial_rx_baud_tick),
    .serial_tx_baud_tick   (serial_tx_baud_tick),
    .timer_a_overflow_flag (timer_a_overflow_flag),
    .timer_b_overflow_flag (timer_b_overflow_flag),
    .timer_c_overflow_flag (timer_c_overflow_flag),
    .timer_c_external_flag (timer_c_external_flag)
  );

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (serial_rx_baud_tick === 1'b1) rx_ticks++;
    if (serial_tx_baud_tick === 1'b1) tx_ticks++;
  end

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge
  // A stuck slave is ended by the watchdog
  task automatic bus(input logic [7:0] idx, input logic wr_en, input logic [7:0] wd);
    @(posedge ref_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_write     <= wr_en;
    avs_read      <= ~wr_en;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
    bus(idx, 1'b0, 8'h00);
    chk(what, exp, rd);
  endtask : rdc

  // Falling edges on the count pin or the trigger pin, high between
  task automatic pulse(input int n, input bit trig);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (trig) timer_c_trigger_pin <= 1'b0;
      else timer_c_count_pin <= 1'b0;
      repeat (3) @(posedge ref_clk);
      timer_c_trigger_pin <= 1'b1;
      timer_c_count_pin   <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
  endtask : pulse

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    $display("unexpected run length: expected end, seen timeout");
    complete_run();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (regs[i]) rdc(regs[i], REG_RESET, "reset value");
    wr(8'h90, 8'hA5);
    rdc(8'h90, 8'h00, "unmapped index");
    // Timer A in modes 0, 1 and 2, three counts from overflow
    for (int m = 0; m < 3; m++) begin
      wr(IDX_AB_MODE, 8'(m));
      wr(IDX_A_HIGH, hw[m]);
      wr(IDX_A_LOW, 8'hFD);
      wr(IDX_AB_CTRL, 8'h10);
      repeat (6) @(posedge ref_clk);
      rdc(IDX_AB_CTRL, 8'h30, "timer A overflow");
      chk("timer A flag pin", 8'h01, {7'h00, timer_a_overflow_flag});
      wr(IDX_AB_CTRL, 8'h00);
      rdc(IDX_A_HIGH, he[m], "timer A high byte");
      bus(IDX_A_LOW, 1'b0, 8'h00);
      chk("timer A low top bits", top[m], rd & msk[m]);
    end
    ext_irq_a_pin <= 1'b0;
    wr(IDX_AB_MODE, 8'h09);
    wr(IDX_A_LOW, 8'h00);
    wr(IDX_AB_CTRL, 8'h10);
    repeat (8) @(posedge ref_clk);
    rdc(IDX_A_LOW, 8'h00, "gated timer A");
    ext_irq_a_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    wr(IDX_AB_CTRL, 8'h00);
    bus(IDX_A_LOW, 1'b0, 8'h00);
    chk("ungated timer A moved", 8'h01, {7'h00, rd != 8'h00});
    // Split timer A, frozen timer B
    wr(IDX_AB_MODE, 8'h33);
    wr(IDX_B_LOW, 8'h55);
    wr(IDX_A_HIGH, 8'hFE);
    wr(IDX_AB_CTRL, 8'h40);
    repeat (8) @(posedge ref_clk);
    rdc(IDX_AB_CTRL, 8'hC0, "split high byte overflow");
    rdc(IDX_B_LOW, 8'h55, "frozen timer B");
    wr(IDX_AB_MODE, 8'h13);
    repeat (4) @(posedge ref_clk);
    bus(IDX_B_LOW, 1'b0, 8'h00);
    chk("timer B restarted", 8'h01, {7'h00, rd != 8'h55});
    wr(IDX_AB_MODE, 8'h00);
    wr(IDX_AB_CTRL, 8'h00);
    // Timer C counting pin edges
    wr(IDX_C_CNT_LO, 8'h10);
    wr(IDX_C_CNT_HI, 8'h00);
    wr(IDX_C_CTRL, 8'h06);
    repeat (4) @(posedge ref_clk);
    rdc(IDX_C_CNT_LO, 8'h10, "count kept on run");
    pulse(5, 1'b0);
    rdc(IDX_C_CNT_LO, 8'h15, "pin edges counted");
    wr(IDX_C_CTRL, 8'h02);
    pulse(2, 1'b0);
    rdc(IDX_C_CNT_LO, 8'h15, "stopped timer C");
    // Timer C overflow with reload
    wr(IDX_C_RL_LO, 8'h00);
    wr(IDX_C_RL_HI, 8'hAB);
    wr(IDX_C_CNT_LO, 8'hFD);
    wr(IDX_C_CNT_HI, 8'hFF);
    wr(IDX_C_CTRL, 8'h04);
    repeat (8) @(posedge ref_clk);
    rdc(IDX_C_CTRL, 8'h84, "timer C overflow");
    chk("timer C flag pin", 8'h01, {7'h00, timer_c_overflow_flag});
    rdc(IDX_C_CNT_HI, 8'hAB, "reloaded high byte");
    wr(IDX_C_CTRL, 8'h00);
    // Trigger edge: capture, ignored, reload
    wr(IDX_C_CNT_LO, 8'h3C);
    wr(IDX_C_CNT_HI, 8'h5A);
    wr(IDX_C_CTRL, 8'h09);
    pulse(1, 1'b1);
    rdc(IDX_C_RL_LO, 8'h3C, "captured low byte");
    rdc(IDX_C_RL_HI, 8'h5A, "captured high byte");
    rdc(IDX_C_CTRL, 8'h49, "external flag");
    chk("external flag pin", 8'h01, {7'h00, timer_c_external_flag});
    wr(IDX_C_CTRL, 8'h01);
    wr(IDX_C_CNT_LO, 8'h77);
    pulse(1, 1'b1);
    rdc(IDX_C_RL_LO, 8'h3C, "ignored trigger");
    rdc(IDX_C_CTRL, 8'h01, "no external flag");
    wr(IDX_C_CTRL, 8'h08);
    pulse(1, 1'b1);
    rdc(IDX_C_CNT_LO, 8'h3C, "trigger reload");
    rdc(IDX_C_CTRL, 8'h48, "reload external flag");
    // Timer B reloading from its high byte feeds the receive tick
    rx0 = rx_ticks;
    wr(IDX_B_HIGH, 8'hFC);
    wr(IDX_B_LOW, 8'hFC);
    wr(IDX_AB_MODE, 8'h20);
    wr(IDX_AB_CTRL, 8'h40);
    repeat (16) @(posedge ref_clk);
    rdc(IDX_AB_CTRL, 8'hC0, "timer B overflow");
    wr(IDX_AB_CTRL, 8'h00);
    chk("rx ticks from timer B", 8'h01, {7'h00, (rx_ticks - rx0) >= 3});
    // Baud mode: both selects, capture bit ignored
    wr(IDX_C_RL_LO, 8'hF0);
    wr(IDX_C_RL_HI, 8'hFF);
    wr(IDX_C_CNT_HI, 8'hFF);
    wr(IDX_C_CNT_LO, 8'hF0);
    rx0 = rx_ticks;
    tx0 = tx_ticks;
    wr(IDX_C_CTRL, 8'h35);
    repeat (64) @(posedge ref_clk);
    rdc(IDX_C_CTRL, 8'h35, "no flag in baud mode");
    rdc(IDX_C_CNT_HI, 8'hFF, "forced reload");
    wr(IDX_C_CTRL, 8'h00);
    chk("rx and tx ticks", 8'h01, {7'h00, (rx_ticks - rx0) >= 3 &&
        (rx_ticks - rx0) == (tx_ticks - tx0)});
    rx0 = rx_ticks;
    tx0 = tx_ticks;
    wr(IDX_C_CTRL, 8'h14);
    repeat (64) @(posedge ref_clk);
    wr(IDX_C_CTRL, 8'h00);
    chk("rx ticks from stopped timer B", 8'h00, 8'(rx_ticks - rx0));
    chk("tx ticks from timer C", 8'h01, {7'h00, (tx_ticks - tx0) >= 3});
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
